// File: hdl/iro_counter.sv
// The implementer's own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
// Function
// (RULE1) response queue retry code selected: count each retried response queue transaction
// (RULE2) retry event adds at most one per cycle, only on counters zero or one
// (RULE3) unit mask bit zero counts every tracker reject retry, any cause
// (RULE4) unit mask bit one counts retries from a full egress queue
// (RULE5) unit mask bit three counts retries lacking a free request tracker id
// (RULE6) unit mask bit five counts attempts for the shared io agent credit
// (RULE7) unit mask bit seven counts local write retries lacking writeback credits
// (RULE8) only response queue transactions feed the retry event
// (RULE9) occupancy code selected: add valid entries of chosen ingress queues per cycle
// (RULE10) occupancy adds at most twenty per cycle, only on counter zero
// (RULE11) software never mixes the rejected selection with other occupancy bits
// (RULE12) ordering fifo selection adds its occupied entry count each cycle
// (RULE13) io requests leave the ordering fifo strictly in arrival order
// (RULE14) entry allocated on entry, freed in the cycle it leaves the request queue; here the fifo occupancy drops in the cycle after it leaves
// (RULE15) several compatible occupancy bits add the sum of their queues
module iro_counter
  import iro_pkg::*;
#(
  parameter int CTR_INDEX  = 0,
  parameter int CTR_W      = 48,
  parameter int FIFO_DEPTH = 16,
  parameter int TAG_W      = 8,
  parameter int QOCC_W     = 5
) (
  // clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // avalon-mm slave
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  // response queue retry indications, one cycle each
  input  wire logic              rspq_retry,
  input  wire logic              rspq_rej_egress_full,
  input  wire logic              rspq_rej_no_tracker_id,
  input  wire logic              rspq_rej_link_credits,
  input  wire logic              rspq_io_credit_attempt,
  input  wire logic              rspq_rej_writeback_credits,
  // ingress queue occupancies, valid entries this cycle
  input  wire logic [QOCC_W-1:0] req_queue_occ,
  input  wire logic [QOCC_W-1:0] req_rejected_occ,
  input  wire logic [QOCC_W-1:0] probe_queue_occ,
  // io ordering fifo, allocate side
  input  wire logic              io_alloc_valid,
  input  wire logic [TAG_W-1:0]  io_alloc_tag,
  output logic                   io_alloc_ready,
  // io ordering fifo, release side
  output logic                   io_head_valid,
  output logic      [TAG_W-1:0]  io_head_tag,
  input  wire logic              io_release
);

  localparam int AW    = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
  localparam int OCC_W = $clog2(FIFO_DEPTH + 1);
  localparam logic [OCC_W-1:0] FIFO_FULL_CNT = OCC_W'(FIFO_DEPTH);
  localparam logic [AW-1:0]    LAST_ADDR     = AW'(FIFO_DEPTH - 1);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [31:0]      control;
  logic [CTR_W-1:0] count;
  logic             ack;

  // ordering fifo pointers and fill
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [OCC_W-1:0] fifo_occ;
  logic [AW-1:0]    next_rd_ptr;
  logic [TAG_W-1:0] head_rdata;

  // decoded control fields
  logic [7:0]       evt_code;
  logic [7:0]       umask;
  logic             count_en;

  // fifo handshake terms
  logic             fifo_push;
  logic             fifo_pop;
  logic             fifo_empty;
  logic             fifo_full;

  // event selection terms
  logic             retry_sel;
  logic             occ_sel;
  logic             prog_err;
  logic             retry_hit;
  logic [OCC_INC_W+2:0] occ_sum;
  logic [OCC_INC_W-1:0] occ_inc;
  logic [CTR_W-1:0] inc;

  // bus handshake terms
  logic             bus_req;
  logic             bus_take;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // one selected queue contributes its occupancy, others add nothing
  function automatic logic [OCC_INC_W+2:0] occ_term(input logic sel,
                                                   input logic [QOCC_W-1:0] occ);
    occ_term = sel ? (OCC_INC_W+3)'(occ) : '0;
  endfunction

  // pointer step with wrap at the configured depth
  function automatic logic [AW-1:0] ptr_step(input logic [AW-1:0] p);
    ptr_step = (p == LAST_ADDR) ? '0 : p + AW'(1);
  endfunction

  // merge a bus word into a register under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    be_merge = r;
  endfunction

  // ****************************************************************
  // avalon-mm slave
  // ****************************************************************
  // every access waits exactly one cycle, answer on the second edge
  assign bus_req         = avs_read | avs_write;
  assign bus_take        = bus_req & ack;
  assign avs_waitrequest = bus_req & ~ack;

  // ack pulses for one cycle so back to back requests each get a wait
  // a held request is taken every second cycle, not every cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ack <= 1'b0;
    end else begin
      ack <= bus_req & ~ack;
    end
  end

  // control register, software steers the event selection here
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      control <= CONTROL_RESET;
    end else if (bus_take && avs_write && (avs_address == OFS_CONTROL)) begin
      control <= be_merge(control, avs_writedata, avs_byteenable) & CONTROL_WMASK;
    end
  end

  // field views of the control word
  assign evt_code = control[CTL_CODE_LSB +: 8];
  assign umask    = control[CTL_UMASK_LSB +: 8];
  assign count_en = control[CTL_EN_BIT];

  // read data registered while the request waits; unmapped reads give zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack) begin
      case (avs_address)
        OFS_CONTROL:  avs_readdata <= control;
        OFS_COUNT_LO: avs_readdata <= 32'(count[CTR_W-1:0]);
        OFS_COUNT_HI: avs_readdata <= 32'(count >> 32);
        OFS_STATUS: begin
          // rebuilt from live flags
          avs_readdata <= '0;
          avs_readdata[STS_PROG_ERR_BIT] <= prog_err;
          avs_readdata[STS_FULL_BIT]     <= fifo_full;
          avs_readdata[STS_EMPTY_BIT]    <= fifo_empty;
          avs_readdata[STS_OCC_LSB +: OCC_W] <= fifo_occ;
        end
        default:      avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ****************************************************************
  // event selection
  // ****************************************************************
  // a code placed on a counter that may not carry it counts nothing,
  // so a misprogrammed slot reads a steady value instead of garbage
  assign retry_sel = (evt_code == EVT_RSPQ_RETRY) && (CTR_INDEX <= RETRY_MAX_CTR); // RULE2
  assign occ_sel   = (evt_code == EVT_OCCUPANCY) && (CTR_INDEX <= OCC_MAX_CTR)     // RULE10
                     && !(umask[OCC_REJ_BIT] && (umask != 8'h02));                  // RULE11

  // visible hint to software that the programming above will not count
  assign prog_err = ((evt_code == EVT_RSPQ_RETRY) && (CTR_INDEX > RETRY_MAX_CTR))
                  || ((evt_code == EVT_OCCUPANCY) && (CTR_INDEX > OCC_MAX_CTR))
                  || ((evt_code == EVT_OCCUPANCY) && umask[OCC_REJ_BIT]
                      && (umask != 8'h02));

  // ****************************************************************
  // retry event
  // ****************************************************************
  // only response queue indications reach this term; the request and
  // probe queues have events of their own elsewhere
  always_comb begin
    retry_hit = 1'b0;

    if (rspq_retry) begin                                             // RULE8
      if (umask[RTY_ANY_BIT]) begin
        retry_hit = 1'b1;                                             // RULE3
      end
      if (umask[RTY_FULL_BIT] && rspq_rej_egress_full) begin
        retry_hit = 1'b1;                                             // RULE4
      end
      if (umask[RTY_REQUEST_TRACKER_ID_BIT] && rspq_rej_no_tracker_id) begin
        retry_hit = 1'b1;                                             // RULE5
      end
      // link credit reject, own mask bit
      if (umask[RTY_LINK_BIT] && rspq_rej_link_credits) begin
        retry_hit = 1'b1;
      end
      if (umask[RTY_WB_BIT] && rspq_rej_writeback_credits) begin
        retry_hit = 1'b1;                                             // RULE7
      end
    end
    // credit attempts count whether or not the attempt failed
    if (umask[RTY_IO_BIT] && rspq_io_credit_attempt) begin
      retry_hit = 1'b1;                                               // RULE6
    end
  end

  // ****************************************************************
  // occupancy event
  // ****************************************************************
  // sum of all selected queues, clamped so a broken source can never
  // push more than the documented per-cycle figure into the counter
  always_comb begin
    occ_sum = occ_term(umask[OCC_REQ_BIT],   req_queue_occ)          // RULE15
            + occ_term(umask[OCC_REJ_BIT],   req_rejected_occ)
            + occ_term(umask[OCC_PROBE_BIT], probe_queue_occ)
            + occ_term(umask[OCC_FIFO_BIT],  QOCC_W'(fifo_occ));      // RULE12

    if (occ_sum > (OCC_INC_W+3)'(OCC_MAX_INC)) begin
      occ_inc = OCC_MAX_INC;                                          // RULE10
    end else begin
      occ_inc = occ_sum[OCC_INC_W-1:0];
    end
  end

  // ****************************************************************
  // counter
  // ****************************************************************
  // at most one of the two events is live, so one increment path suffices
  always_comb begin
    inc = '0;

    if (count_en && retry_sel && retry_hit) begin
      inc = CTR_W'(1);                                                // RULE1 RULE2
    end else if (count_en && occ_sel) begin
      inc = CTR_W'(occ_inc);                                          // RULE9
    end
  end

  // a software load wins over counting in the same cycle; the event of
  // that cycle is dropped since software is redefining the value anyway
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= '0;
    end else if (bus_take && avs_write && (avs_address == OFS_COUNT_LO)) begin
      // a low word load keeps the high word
      count <= CTR_W'({count >> 32, be_merge(32'(count[CTR_W-1:0]),
                                             avs_writedata, avs_byteenable)});
    end else if (bus_take && avs_write && (avs_address == OFS_COUNT_HI)) begin
      // a high word load keeps the low word
      count <= CTR_W'({be_merge(32'(count >> 32), avs_writedata, avs_byteenable),
                       32'(count[CTR_W-1:0])});
    end else begin
      count <= count + inc;
    end
  end

  // ****************************************************************
  // io ordering fifo
  // ****************************************************************
  // entries only leave from the head, which keeps io requests in order
  assign fifo_empty     = (fifo_occ == '0);
  assign fifo_full      = (fifo_occ == FIFO_FULL_CNT);
  assign io_alloc_ready = ~fifo_full;

  // refused pushes and releases simply wait
  assign fifo_push      = io_alloc_valid & io_alloc_ready;            // RULE14
  assign fifo_pop       = io_release & ~fifo_empty;                   // RULE13

  // read address looks one pop ahead
  assign next_rd_ptr    = fifo_pop ? ptr_step(rd_ptr) : rd_ptr;

  // pointers advance on allocation and on release of the head
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (fifo_push) begin
        wr_ptr <= ptr_step(wr_ptr);
      end
      rd_ptr <= next_rd_ptr;                                          // RULE13
    end
  end

  // occupancy drops in the cycle after the transaction leaves the queue
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fifo_occ <= '0;
    end else begin
      case ({fifo_push, fifo_pop})
        2'b10:   fifo_occ <= fifo_occ + OCC_W'(1);                    // RULE14
        2'b01:   fifo_occ <= fifo_occ - OCC_W'(1);                    // RULE14
        // push with pop keeps the fill
        default: fifo_occ <= fifo_occ;
      endcase
    end
  end

  // tag storage, read address runs one step ahead so the head is ready
  iro_fifo_mem #(
    .WIDTH (TAG_W),
    .DEPTH (FIFO_DEPTH),
    .AW    (AW)
  ) u_mem (
    .clk   (clk),
    .we    (fifo_push),
    .waddr (wr_ptr),
    .wdata (io_alloc_tag),
    .raddr (next_rd_ptr),
    .rdata (head_rdata)
  );

  // head presentation; empty shows a zero tag
  // so a stale tag never looks live
  assign io_head_valid = ~fifo_empty;
  assign io_head_tag   = fifo_empty ? '0 : head_rdata;

endmodule

// File: hdl/iro_pkg.sv
package iro_pkg;

  // ****************************************************************
  // register map, byte addresses on the avalon slave
  // ****************************************************************
  localparam logic [3:0] OFS_CONTROL   = 4'h0;
  localparam logic [3:0] OFS_COUNT_LO  = 4'h4;
  localparam logic [3:0] OFS_COUNT_HI  = 4'h8;
  localparam logic [3:0] OFS_STATUS    = 4'hc;

  // ****************************************************************
  // control register fields
  // ****************************************************************
  localparam int CTL_CODE_LSB  = 0;   // event select [7:0]
  localparam int CTL_UMASK_LSB = 8;   // unit mask [15:8]
  localparam int CTL_EN_BIT    = 22;  // counting enable
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] CONTROL_WMASK = 32'h0040_ffff;

  // ****************************************************************
  // status register fields
  // ****************************************************************
  localparam int STS_PROG_ERR_BIT = 0;
  localparam int STS_FULL_BIT     = 1;
  localparam int STS_EMPTY_BIT    = 2;
  localparam int STS_OCC_LSB      = 8;

  // ****************************************************************
  // event codes
  // ****************************************************************
  localparam logic [7:0] EVT_RSPQ_RETRY = 8'h33;
  localparam logic [7:0] EVT_OCCUPANCY  = 8'h11;

  // ****************************************************************
  // unit mask bits of the response queue retry event
  // ****************************************************************
  localparam int RTY_ANY_BIT   = 0;
  localparam int RTY_FULL_BIT  = 1;
  localparam int RTY_REQUEST_TRACKER_ID_BIT  = 3;
  localparam int RTY_LINK_BIT  = 4;
  localparam int RTY_IO_BIT    = 5;
  localparam int RTY_WB_BIT    = 7;

  // ****************************************************************
  // unit mask bits of the occupancy event
  // ****************************************************************
  localparam int OCC_REQ_BIT   = 0;
  localparam int OCC_REJ_BIT   = 1;
  localparam int OCC_PROBE_BIT = 2;
  localparam int OCC_FIFO_BIT  = 4;

  // ****************************************************************
  // per-cycle increment limits and counter placement
  // ****************************************************************
  localparam int OCC_INC_W      = 5;
  localparam logic [4:0] OCC_MAX_INC = 5'h14;  // twenty per cycle
  localparam int RETRY_MAX_CTR  = 1;           // counters zero and one
  localparam int OCC_MAX_CTR    = 0;           // counter zero only

endpackage

// File: hdl/iro_fifo_mem.sv
`timescale 1ns/1ps
module iro_fifo_mem
  import iro_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // clock
  input  wire logic             clk,
  // write port
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  // read port, registered data
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ****************************************************************
  // storage
  // ****************************************************************
  // plain array write, no reset needed on storage
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // write-first read so a tag pushed into an empty queue shows at once
  always_ff @(posedge clk) begin
    if (we && (waddr == raddr)) begin
      rdata <= wdata;
    end else begin
      rdata <= mem[raddr];
    end
  end

endmodule

// File: sim/iro_counter_props.sv
`timescale 1ns/1ps
// ********************************
// port-level checker for the counter block
// ********************************
module iro_counter_props
  import iro_pkg::*;
#(
  parameter int FIFO_DEPTH = 16,
  parameter int TAG_W      = 8
) (
  // clock and reset
  input wire logic             clk,
  input wire logic             rst_n,
  // avalon-mm slave
  input wire logic [3:0]       avs_address,
  input wire logic             avs_read,
  input wire logic             avs_write,
  input wire logic [31:0]      avs_readdata,
  input wire logic             avs_waitrequest,
  // io ordering fifo
  input wire logic             io_alloc_valid,
  input wire logic [TAG_W-1:0] io_alloc_tag,
  input wire logic             io_alloc_ready,
  input wire logic             io_head_valid,
  input wire logic [TAG_W-1:0] io_head_tag,
  input wire logic             io_release
);
  logic [7:0] fill;

  // shadow fill level from accepted pushes and pops, the flags are judged against it
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fill <= 8'h00;
    end else begin
      fill <= fill + 8'(io_alloc_valid & io_alloc_ready) - 8'(io_release & io_head_valid);
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  AST_WAIT_ONE: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest ##1 !avs_waitrequest)
    else $error("bus access did not get exactly one wait cycle");
  AST_IDLE_NO_WAIT: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest raised with no access");
  AST_READY_FULL: assert property (io_alloc_ready == (fill != 8'(FIFO_DEPTH)))
    else $error("allocate ready does not follow the fill level");
  AST_HEAD_VALID: assert property (io_head_valid == (fill != 8'h00))
    else $error("head valid does not follow the fill level");
  AST_HEAD_HOLD: assert property (io_head_valid && !io_release |=>
    io_head_valid && $stable(io_head_tag))
    else $error("head tag moved without a release");
  AST_FIRST_TAG: assert property (!io_head_valid && io_alloc_valid |=>
    io_head_tag == $past(io_alloc_tag))
    else $error("first entry of an empty fifo not at the head");
  AST_STATUS_OCC: assert property (avs_read && !avs_waitrequest &&
    avs_address == OFS_STATUS |-> avs_readdata[STS_OCC_LSB +: 5] == $past(fill[4:0]) &&
    avs_readdata[STS_FULL_BIT] == ($past(fill) == 8'(FIFO_DEPTH)))
    else $error("status occupancy or full flag wrong");
  AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'b00 |->
    avs_readdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  AST_HI_UPPER: assert property (avs_read && !avs_waitrequest && avs_address == OFS_COUNT_HI |->
    avs_readdata[31:16] == 16'h0)
    else $error("count high word upper half not zero");
endmodule

bind iro_counter iro_counter_props #(.FIFO_DEPTH(FIFO_DEPTH), .TAG_W(TAG_W)) props_u (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .io_alloc_valid(io_alloc_valid), .io_alloc_tag(io_alloc_tag), .io_alloc_ready(io_alloc_ready),
  .io_head_valid(io_head_valid), .io_head_tag(io_head_tag), .io_release(io_release));

// File: sim/iro_ingress_model.sv
`timescale 1ns/1ps
// ********************************
// stand-in for the ingress queues and tracker pipeline
// ********************************
module iro_ingress_model (
  // clock
  input wire logic   clk,
  // retry indications and queue occupancies
  output logic [5:0]  rv,
  output logic [14:0] occ,
  // ordering fifo allocate and release
  output logic        io_alloc_valid,
  output logic [7:0]  io_alloc_tag,
  output logic        io_release
);
  // quiet at time zero
  initial begin
    rv = 6'h00;
    occ = 15'h0000;
    io_alloc_valid = 1'b0;
    io_alloc_tag = 8'h00;
    io_release = 1'b0;
  end

  // causes only ever come from response queue transactions, one retry per cycle
  task automatic drive(input logic [5:0] r, input logic [14:0] o);
    rv <= r;
    occ <= o;
  endtask

  // allocate on entry, back to back when called at consecutive edges
  task automatic push(input logic [7:0] t);
    io_alloc_valid <= 1'b1;
    io_alloc_tag <= t;
    @(posedge clk);
  endtask

  // a released tag line shows the inverse, so a stale value cannot pass for a real one
  task automatic idle();
    io_alloc_valid <= 1'b0;
    io_alloc_tag <= ~io_alloc_tag;
  endtask

  // the head leaves the request queue for one cycle, then a gap
  task automatic pop();
    @(posedge clk);
    io_release <= 1'b1;
    @(posedge clk);
    io_release <= 1'b0;
  endtask
endmodule

// File: sim/tb.sv
`timescale 1ns/1ps
module tb;
  import iro_pkg::*;
  typedef struct packed {
    logic [31:0] ctl;
    logic [5:0]  rv;
    logic [14:0] occ;
    logic [31:0] exp;
    logic        err;
  } iro_row_t;

  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [31:0] rd;
  logic [5:0]  rv;
  logic [14:0] occ;
  logic        av, ar, hv, rel;
  logic [7:0]  at, ht;
  logic [31:0] acc = 32'h0;
  logic [31:0] acc0;
  logic [7:0]  occ_ref = 8'h00;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  // rv is {retry, egress full, no id, link, io attempt, writeback}; occ is {req, rejected, probe}
  iro_row_t rows [14] = '{
    '{32'h0040_0133, 6'b100000, 15'h0000, 32'd3, 1'b0},
    '{32'h0040_0233, 6'b110000, 15'h0000, 32'd3, 1'b0},
    '{32'h0040_0233, 6'b100000, 15'h0000, 32'd0, 1'b0},
    '{32'h0040_0233, 6'b010000, 15'h0000, 32'd0, 1'b0},
    '{32'h0040_0833, 6'b101000, 15'h0000, 32'd3, 1'b0},
    '{32'h0040_1033, 6'b100100, 15'h0000, 32'd3, 1'b0},
    '{32'h0040_2033, 6'b000010, 15'h0000, 32'd3, 1'b0},
    '{32'h0040_8033, 6'b100001, 15'h0000, 32'd3, 1'b0},
    '{32'h0040_8b33, 6'b111001, 15'h0000, 32'd3, 1'b0},
    '{32'h0040_0111, 6'b000000, 15'h1c00, 32'd21, 1'b0},
    '{32'h0040_0511, 6'b000000, 15'h1c04, 32'd33, 1'b0},
    '{32'h0040_0511, 6'b000000, 15'h3c09, 32'd60, 1'b0},
    '{32'h0040_0211, 6'b000000, 15'h24c0, 32'd18, 1'b0},
    '{32'h0040_0311, 6'b000000, 15'h24c0, 32'd0, 1'b1}};

  always #5 clk = ~clk;

  iro_counter dut_u (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .rspq_retry(rv[5]), .rspq_rej_egress_full(rv[4]), .rspq_rej_no_tracker_id(rv[3]),
    .rspq_rej_link_credits(rv[2]), .rspq_io_credit_attempt(rv[1]),
    .rspq_rej_writeback_credits(rv[0]), .req_queue_occ(occ[14:10]),
    .req_rejected_occ(occ[9:5]), .probe_queue_occ(occ[4:0]), .io_alloc_valid(av),
    .io_alloc_tag(at), .io_alloc_ready(ar), .io_head_valid(hv), .io_head_tag(ht),
    .io_release(rel));

  iro_ingress_model model_u (
    .clk(clk), .rv(rv), .occ(occ), .io_alloc_valid(av), .io_alloc_tag(at), .io_release(rel));

  // reference fill level and running occupancy sum, taken from the wires we drive
  always @(posedge clk) begin
    acc <= acc + 32'(occ_ref);
    if (!rst_n) occ_ref <= 8'h00;
    else occ_ref <= occ_ref + 8'(av && occ_ref < 8'd16) - 8'(rel && occ_ref != 8'd0);
  end

  // hang guard, far above the few hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask

  // one access, held until waitrequest is sampled low at a rising edge; data taken there
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input string n, input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask

  // ********************************
  // main sequence
  // ********************************
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdchk("control reset", OFS_CONTROL, CONTROL_RESET);
    rdchk("count lo reset", OFS_COUNT_LO, 32'h0);
    rdchk("status reset", OFS_STATUS, 32'h0000_0004);
    foreach (rows[i]) begin
      bus(1'b1, OFS_CONTROL, 32'h0);
      bus(1'b1, OFS_COUNT_LO, 32'h0);
      bus(1'b1, OFS_COUNT_HI, 32'h0);
      bus(1'b1, OFS_CONTROL, rows[i].ctl);
      model_u.drive(rows[i].rv, rows[i].occ);
      repeat (3) @(posedge clk);
      model_u.drive(6'h00, 15'h0000);
      @(posedge clk);
      rdchk("count", OFS_COUNT_LO, rows[i].exp);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("program error", 32'(rows[i].err), 32'(rd[STS_PROG_ERR_BIT]));
    end
    // low word wrap carries into the high word
    bus(1'b1, OFS_CONTROL, 32'h0);
    bus(1'b1, OFS_COUNT_LO, 32'hffff_ffff);
    bus(1'b1, OFS_COUNT_HI, 32'h0);
    bus(1'b1, OFS_CONTROL, 32'h0040_0133);
    model_u.drive(6'b100000, 15'h0000);
    @(posedge clk);
    model_u.drive(6'h00, 15'h0000);
    @(posedge clk);
    rdchk("count lo wrap", OFS_COUNT_LO, 32'h0);
    rdchk("count hi carry", OFS_COUNT_HI, 32'h1);
    // read-only status and an unmapped place
    bus(1'b1, OFS_CONTROL, 32'h0);
    bus(1'b1, OFS_STATUS, 32'hffff_ffff);
    rdchk("status after write", OFS_STATUS, 32'h0000_0004);
    rdchk("unmapped", 4'h2, 32'h0);
    // fill the ordering fifo past full, then drain it in order
    bus(1'b1, OFS_COUNT_LO, 32'h0);
    bus(1'b1, OFS_COUNT_HI, 32'h0);
    bus(1'b1, OFS_CONTROL, 32'h0040_1011);
    acc0 = acc;
    for (int i = 0; i < 17; i++) model_u.push(8'h10 + 8'(i));
    model_u.idle();
    @(negedge clk);
    chk("alloc ready when full", 32'h0, 32'(ar));
    @(posedge clk);
    rdchk("status full", OFS_STATUS, 32'h0000_1002);
    for (int i = 0; i < 16; i++) begin
      @(negedge clk);
      chk("head", 32'h0000_0110 + 32'(i), 32'({hv, ht}));
      model_u.pop();
    end
    @(negedge clk);
    chk("head after drain", 32'h0, 32'(hv));
    @(posedge clk);
    rdchk("ordering fifo occupancy sum", OFS_COUNT_LO, acc - acc0);
    // reset in mid-run with entries held
    model_u.push(8'h55);
    model_u.push(8'h66);
    model_u.idle();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk("fifo after reset", 32'h1, 32'({hv, ar}));
    @(posedge clk);
    rdchk("control after reset", OFS_CONTROL, CONTROL_RESET);
    rdchk("count after reset", OFS_COUNT_LO, 32'h0);
    wrap_up();
  end
endmodule
